// File: common/exec_pkg.sv
// Purpose: Shared constants for the three-instruction execute block
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit file registers
// Notes:   Every opcode pattern and field position lives here once, with the PC reset value and the clear value
package exec_pkg;

  // Instruction word and datapath widths
  localparam int INSN_W      = 14;          // Instruction word width
  localparam int PC_W        = 13;          // Program counter width
  localparam int DATA_W      = 8;           // File register width
  localparam int FADDR_W     = 7;           // File register address width
  localparam int BIT_W       = 3;           // Bit-select field width
  localparam int K_W         = 11;          // Call immediate width
  localparam int FILE_DEPTH  = 128;         // Addressable file registers

  // Field positions inside the word
  localparam int FADDR_LSB   = 0;           // Register address field
  localparam int BIT_LSB     = 7;           // Bit-select field
  localparam int K_LSB       = 0;           // Call immediate field

  // Opcode patterns, compared against the top bits of the word
  localparam logic [3:0] OPC_SKIP  = 4'h7;  // Bits 13:10 of bit_set_skip
  localparam logic [2:0] OPC_CALL  = 3'h4;  // Bits 13:11 of call
  localparam logic [6:0] OPC_CLEAR = 7'h03; // Bits 13:7 of register_clear

  // Latch bits copied into the upper program counter on a call
  localparam int ULA_HI      = 4;
  localparam int ULA_LO      = 3;

  // Values written or reset
  localparam logic [DATA_W-1:0] CLEAR_VAL  = 8'h00;   // Written by register_clear
  localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;

  // Execute sequencer states, one-hot
  typedef enum logic [2:0]
  {
    ST_RUN  = 3'h1,   // Normal execution of the arriving word
    ST_TEST = 3'h2,   // A skip test decides the fate of this word
    ST_CALL = 3'h4    // Slot after a call, always discarded
  } exec_state_t;

endpackage : exec_pkg

// File: rtl/file_ram.sv
// Purpose: File register storage with one write port and a registered read port
// Assumes: Single clock; write and read in the same cycle return the old data
// Notes:   Contents are not reset, as in a real register file
`timescale 1ns/1ps
`default_nettype none

module file_ram #(
  parameter int DEPTH  = 128,
  parameter int AW     = 7,
  parameter int DW     = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata_q
);

  // The address must reach every word; DEPTH may lie anywhere from 1 up to the full address range
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_depth_check
    $error("DEPTH does not fit the address width");
  end

  // Storage array
  logic [DW-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read port; data holds until the next enabled read
  always_ff @(posedge clk)
  begin
    if (re)
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : file_ram

`default_nettype wire

// File: rtl/insn_exec.sv
// Purpose: Execute bit_set_skip, call and register_clear for an 8-bit core
// Assumes: One instruction word offered per cycle on insn_valid; other opcodes step the PC only
// Notes:   A discarded slot still consumes a valid word; its cycle shows as nop_q next cycle
`timescale 1ns/1ps
`default_nettype none

module insn_exec #(
  parameter int FILE_DEPTH = exec_pkg::FILE_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        insn_valid,
  input  wire logic [exec_pkg::INSN_W-1:0] insn,
  input  wire logic [7:0]                  upper_address_latch,
  input  wire logic                        zero_clr,
  input  wire logic                        ext_we,
  input  wire logic [exec_pkg::FADDR_W-1:0] ext_addr,
  input  wire logic [exec_pkg::DATA_W-1:0] ext_wdata,
  output var  logic [exec_pkg::PC_W-1:0]   pc_q,
  output var  logic                        push_q,
  output var  logic [exec_pkg::PC_W-1:0]   stack_top_q,
  output var  logic                        zero_q,
  output var  logic                        nop_q
);

  // The address field must be able to reach every file register
  if (FILE_DEPTH < exec_pkg::FILE_DEPTH || FILE_DEPTH > (1 << exec_pkg::FADDR_W))
  begin : g_depth_check
    $error("FILE_DEPTH must lie between 128 and the address range");
  end

  // Opcode recognisers, each used once by the decoder
  function automatic logic is_skip(input logic [exec_pkg::INSN_W-1:0] w);
    return w[13:10] == exec_pkg::OPC_SKIP;
  endfunction : is_skip

  function automatic logic is_call(input logic [exec_pkg::INSN_W-1:0] w);
    return w[13:11] == exec_pkg::OPC_CALL;
  endfunction : is_call

  function automatic logic is_clear(input logic [exec_pkg::INSN_W-1:0] w);
    return w[13:7] == exec_pkg::OPC_CLEAR;
  endfunction : is_clear

  // Sequencer and pending test state
  exec_pkg::exec_state_t           state_q;     // Current slot kind
  exec_pkg::exec_state_t           state_d;
  logic [exec_pkg::BIT_W-1:0]      test_bit_q;  // Bit under test
  logic [exec_pkg::PC_W-1:0]       pc_d;
  logic [exec_pkg::DATA_W-1:0]     rdata_q;     // Tested register contents

  // Field extraction
  wire [exec_pkg::FADDR_W-1:0] f_addr  = insn[exec_pkg::FADDR_LSB +: exec_pkg::FADDR_W];
  wire [exec_pkg::BIT_W-1:0]   f_bit   = insn[exec_pkg::BIT_LSB +: exec_pkg::BIT_W];
  wire [exec_pkg::K_W-1:0]     f_k     = insn[exec_pkg::K_LSB +: exec_pkg::K_W];

  // Slot classification: the tested bit is read one cycle after the skip word,
  // exactly when the already fetched next word arrives, so no stall is needed
  wire bit_hit  = rdata_q[test_bit_q];
  wire drop     = insn_valid && ((state_q == exec_pkg::ST_CALL) ||
                                 ((state_q == exec_pkg::ST_TEST) && bit_hit));
  wire run      = insn_valid && !drop;
  wire do_skip  = run && is_skip(insn);
  wire do_call  = run && is_call(insn);
  wire do_clear = run && is_clear(insn);

  // Call target and return address
  wire [exec_pkg::PC_W-1:0] call_target = {upper_address_latch[exec_pkg::ULA_HI:exec_pkg::ULA_LO], f_k};
  wire [exec_pkg::PC_W-1:0] pc_next     = pc_q + exec_pkg::PC_STEP;

  // File write port: the clear has priority over the outside write port
  wire                           ram_we    = do_clear || ext_we;
  wire [exec_pkg::FADDR_W-1:0]   ram_waddr = do_clear ? f_addr : ext_addr;
  wire [exec_pkg::DATA_W-1:0]    ram_wdata = do_clear ? exec_pkg::CLEAR_VAL : ext_wdata;

  // File register storage
  file_ram #(
    .DEPTH   (FILE_DEPTH),
    .AW      (exec_pkg::FADDR_W),
    .DW      (exec_pkg::DATA_W)
  ) u_file (
    .clk     (clk),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .re      (do_skip),
    .raddr   (f_addr),
    .rdata_q (rdata_q)
  );

  // Next state: a gap in the word stream freezes the sequencer
  always_comb
  begin
    state_d = state_q;
    if (!insn_valid)
    begin
      state_d = state_q;
    end
    else if (drop)
    begin
      state_d = exec_pkg::ST_RUN;
    end
    else if (do_call)
    begin
      state_d = exec_pkg::ST_CALL;
    end
    else if (do_skip)
    begin
      state_d = exec_pkg::ST_TEST;
    end
    else
    begin
      state_d = exec_pkg::ST_RUN;
    end
  end

  // Program counter: the slot after a call already holds the target,
  // while a skipped slot steps past the discarded word
  always_comb
  begin
    case (state_q)
      exec_pkg::ST_RUN, exec_pkg::ST_TEST, exec_pkg::ST_CALL:
      begin
        if (!insn_valid)
        begin
          pc_d = pc_q;
        end
        else if (drop && state_q == exec_pkg::ST_CALL)
        begin
          pc_d = pc_q;
        end
        else if (do_call)
        begin
          pc_d = call_target;
        end
        else
        begin
          pc_d = pc_next;
        end
      end
      default:
      begin
        pc_d = pc_q;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= exec_pkg::ST_RUN;
      test_bit_q <= '0;
      pc_q       <= exec_pkg::PC_RST;
    end
    else
    begin
      state_q    <= state_d;
      pc_q       <= pc_d;
      if (do_skip)
      begin
        test_bit_q <= f_bit;
      end
    end
  end

  // Stack push: one-cycle strobe with the return address
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      push_q      <= 1'b0;
      stack_top_q <= exec_pkg::PC_RST;
    end
    else
    begin
      push_q <= do_call;
      if (do_call)
      begin
        stack_top_q <= pc_next;
      end
    end
  end

  // Zero flag: the set wins over a clear in the same cycle; skip and call leave it alone
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_q <= 1'b0;
    end
    else if (do_clear)
    begin
      zero_q <= 1'b1;
    end
    else if (zero_clr)
    begin
      zero_q <= 1'b0;
    end
  end

  // Discard marker: high for one cycle after a word executed as no-operation
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nop_q <= 1'b0;
    end
    else
    begin
      nop_q <= drop;
    end
  end

  // Checks next to the logic they guard
  sequence s_skip_hit;
    state_q == exec_pkg::ST_TEST && insn_valid && rdata_q[test_bit_q];
  endsequence

  sequence s_call_then_word;
    do_call ##1 insn_valid;
  endsequence

  AST_SKIP_FIELDS: assert property (@(posedge clk) disable iff (!arst_n)
    do_skip |=> (state_q == exec_pkg::ST_TEST) && (test_bit_q == $past(insn[9:7])))
    else $error("Skip word did not capture its bit select");

  AST_SKIP_DISCARD: assert property (@(posedge clk) disable iff (!arst_n)
    s_skip_hit |=> nop_q && (pc_q == $past(pc_q) + 13'h0001) && !push_q)
    else $error("Set bit did not discard the next word");

  AST_SKIP_MISS: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == exec_pkg::ST_TEST && insn_valid && !rdata_q[test_bit_q]) |=> !nop_q)
    else $error("Clear bit discarded the next word");

  AST_SKIP_FLAGS: assert property (@(posedge clk) disable iff (!arst_n)
    (do_skip && !zero_clr) |=> $stable(zero_q))
    else $error("Skip changed the zero flag");

  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (!arst_n)
    do_call |=> push_q && (stack_top_q == $past(pc_q) + 13'h0001) ##1 !push_q)
    else $error("Call pushed a wrong return address");

  AST_CALL_TWO_CYCLES: assert property (@(posedge clk) disable iff (!arst_n)
    s_call_then_word |=> nop_q && $stable(pc_q))
    else $error("Slot after a call was not discarded");

  AST_CALL_TARGET: assert property (@(posedge clk) disable iff (!arst_n)
    do_call |=> pc_q == {$past(upper_address_latch[4:3]), $past(insn[10:0])})
    else $error("Call target formed wrongly");

  AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    do_clear |=> zero_q && !nop_q && (pc_q == $past(pc_q) + 13'h0001))
    else $error("Clear did not set the zero flag in one cycle");

endmodule : insn_exec

`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for the skip, call and clear execute block
// Assumes: Outputs show just after the edge that takes a word
// Notes:   File registers are loaded through the test write port
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                          clk;                 // 20 MHz core clock
  logic                          arst_n;              // Active-low reset
  logic                          insn_valid;          // Word offered this cycle
  logic [exec_pkg::INSN_W-1:0]   insn;                // Instruction word
  logic [7:0]                    upper_address_latch; // Upper address source
  logic                          zero_clr;            // Other-instruction zero clear
  logic                          ext_we;              // Test load strobe
  logic [exec_pkg::FADDR_W-1:0]  ext_addr;            // Test load address
  logic [exec_pkg::DATA_W-1:0]   ext_wdata;           // Test load data
  logic [exec_pkg::PC_W-1:0]     pc_q;                // Next address
  logic                          push_q;              // Call push pulse
  logic [exec_pkg::PC_W-1:0]     stack_top_q;         // Return address
  logic                          zero_q;              // Zero flag
  logic                          nop_q;               // Discarded slot pulse
  int                            fails;               // Mismatch count
  int                            n_compared;          // Comparison count
  int                            cycles;              // Hang guard

  insn_exec u_insn_exec (
    .clk                 (clk),
    .arst_n              (arst_n),
    .insn_valid          (insn_valid),
    .insn                (insn),
    .upper_address_latch (upper_address_latch),
    .zero_clr            (zero_clr),
    .ext_we              (ext_we),
    .ext_addr            (ext_addr),
    .ext_wdata           (ext_wdata),
    .pc_q                (pc_q),
    .push_q              (push_q),
    .stack_top_q         (stack_top_q),
    .zero_q              (zero_q),
    .nop_q               (nop_q)
  );

  // Half period of 25 ns gives 20 MHz
  always #25 clk = ~clk;

  // Prints the verdict; the single place where the run ends
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Ceiling well above the roughly 44 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // Case-equality compare, so an unknown never matches
  task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Offers one word just after an edge and lets the taking edge land
  task automatic issue(input logic [13:0] w);
    insn       = w;
    insn_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask : issue

  // Loads a register and clears zero alongside a plain word, so nothing waits on a frozen pipe
  task automatic prep(input logic [6:0] a, input logic [7:0] d);
    ext_we    = 1'b1;
    ext_addr  = a;
    ext_wdata = d;
    zero_clr  = 1'b1;
    issue(14'h0000);
    ext_we    = 1'b0;
    zero_clr  = 1'b0;
    check({12'h000, zero_q}, 13'h0000, "zero not cleared");
  endtask : prep

  // Skip test; the following clear word shows by zero_q whether it ran
  task automatic skip_case(input logic [2:0] b, input logic [6:0] f, input logic [7:0] d, input logic taken);
    logic [12:0] pc0;
    prep(f, d);
    pc0 = pc_q;
    issue({4'h7, b, f});
    check(pc_q, pc0 + 13'h0001, "skip pc");
    check({12'h000, nop_q}, 13'h0000, "skip own nop");
    issue({7'h03, 7'h11});
    check(pc_q, pc0 + 13'h0002, "slot pc");
    check({12'h000, nop_q}, {12'h000, taken}, "slot discard");
    check({12'h000, zero_q}, {12'h000, ~taken}, "slot effect");
  endtask : skip_case

  // Call, then its discarded slot, then a normal word
  task automatic call_case(input logic [7:0] ula, input logic [10:0] k);
    logic [12:0] pc0;
    prep(7'h01, 8'h00);
    upper_address_latch = ula;
    pc0 = pc_q;
    issue({3'h4, k});
    check({12'h000, push_q}, 13'h0001, "push pulse");
    check(stack_top_q, pc0 + 13'h0001, "return");
    check(pc_q, {ula[4:3], k}, "call target");
    issue({7'h03, 7'h02});
    check({12'h000, push_q}, 13'h0000, "push width");
    check({12'h000, nop_q}, 13'h0001, "call slot");
    check(pc_q, {ula[4:3], k}, "slot pc");
    check({12'h000, zero_q}, 13'h0000, "call flags");
    issue(14'h0000);
    check(pc_q, {ula[4:3], k} + 13'h0001, "after");
    check({12'h000, nop_q}, 13'h0000, "after nop");
  endtask : call_case

  // Clear against a same-cycle load and zero clear, then a skip proves bit 5 of the register is clear;
  // both strobes stay up across the load word and the clear word, so neither toggles in one step
  task automatic clear_case;
    logic [12:0] pc0;
    ext_we    = 1'b1;
    ext_addr  = 7'h33;
    ext_wdata = 8'hff;
    zero_clr  = 1'b1;
    issue(14'h0000);
    pc0       = pc_q;
    check({12'h000, zero_q}, 13'h0000, "zero not cleared");
    issue({7'h03, 7'h33});
    ext_we    = 1'b0;
    zero_clr  = 1'b0;
    check({12'h000, zero_q}, 13'h0001, "zero set");
    check(pc_q, pc0 + 13'h0001, "clear pc");
    issue({4'h7, 3'h5, 7'h33});
    issue(14'h0000);
    check({12'h000, nop_q}, 13'h0000, "cleared bit");
    check({12'h000, zero_q}, 13'h0001, "skip keeps zero");
  endtask : clear_case

  // Main sequence: reset, reset values, then every scenario
  initial
  begin
    clk                 = 1'b0;
    arst_n              = 1'b0;
    insn_valid          = 1'b0;
    insn                = 14'h0000;
    upper_address_latch = 8'h00;
    zero_clr            = 1'b0;
    ext_we              = 1'b0;
    ext_addr            = 7'h00;
    ext_wdata           = 8'h00;
    fails               = 0;
    n_compared          = 0;
    cycles              = 0;
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    check(pc_q, 13'h0000, "reset pc");
    check({10'h000, push_q, zero_q, nop_q}, 13'h0000, "reset flags");
    check(stack_top_q, 13'h0000, "reset stack");
    skip_case(3'h7, 7'h7f, 8'h80, 1'b1);
    skip_case(3'h0, 7'h00, 8'hfe, 1'b0);
    skip_case(3'h4, 7'h40, 8'h10, 1'b1);
    skip_case(3'h4, 7'h41, 8'hef, 1'b0);
    call_case(8'hf7, 11'h5a3);
    call_case(8'h08, 11'h7ff);
    call_case(8'he7, 11'h000);
    clear_case();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
